// file: design/conv_sequencer.sv
// conversion sequencer: paces sample requests over the enabled channels
// assumes a same-clock front end that answers each request with done
`timescale 1ns/10ps
`default_nettype none
`include "rtd_mux_consts.svh"

module conv_sequencer
  import rtd_mux_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = `CONV_PERIOD_CYC,
  parameter int unsigned TMO_CYC    = `CONV_TMO_CYC
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       conv_enable,
  input  wire chan_type   count_sel,
  input  wire logic       sample_done,
  input  wire logic       sample_open,
  input  wire sample_type sample_value,
  output var  logic       req,
  output var  chan_type   req_chan,
  output var  logic       busy,
  output var  store_type  store
);

  logic [15:0]    tick_cnt_r;
  logic           tick_r;
  logic [15:0]    wait_cnt_r;
  chan_type       chan_r;
  conv_state_type state_r;

  // pacing divider, free running so scans never wait on it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 16'h0000;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == 16'(PERIOD_CYC - 1)) begin
      tick_cnt_r <= 16'h0000;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
      tick_r     <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= CONV_IDLE;
      chan_r     <= 3'h0;
      wait_cnt_r <= 16'h0000;
      req        <= 1'b0;
      req_chan   <= 3'h0;
      store      <= '0;
    end else begin
      req   <= 1'b0;
      store <= '0;
      case (state_r)
        CONV_IDLE: begin
          if (tick_r && conv_enable) begin
            req        <= 1'b1;
            req_chan   <= (chan_r > count_sel) ? 3'h0 : chan_r;
            chan_r     <= (chan_r > count_sel) ? 3'h0 : chan_r;
            wait_cnt_r <= 16'h0000;
            state_r    <= CONV_WAIT;
          end
        end
        CONV_WAIT: begin
          wait_cnt_r <= wait_cnt_r + 16'h0001;
          if (sample_done) begin
            store   <= '{1'b1, chan_r, sample_open, sample_value};
            chan_r  <= next_chan(chan_r, count_sel);
            state_r <= CONV_IDLE;
          end else if (wait_cnt_r == 16'(TMO_CYC - 1)) begin
            // silent front end reads as an open sensor
            store   <= '{1'b1, chan_r, 1'b1, 16'h0000};
            chan_r  <= next_chan(chan_r, count_sel);
            state_r <= CONV_IDLE;
          end
        end
        default: state_r <= CONV_IDLE;
      endcase
    end
  end

  assign busy = (state_r == CONV_WAIT);

endmodule

`default_nettype wire

// file: design/rtd_channel_mux_reporter.sv
// rtd channel multiplexer reporter: eight converted channels presented
// to a controller as a 32-bit input image over an apb slave
// assumes an apb master on pclk and a same-clock converter front end
//
// Operation
// - one channel's value delivered per host input scan.
// - after the last enabled channel, restart at channel 1.
// - disabled channels are skipped during rotation.
// - a single enabled channel is presented on every scan.
// - conversion runs continuously, independent of the scan; hand-off follows scan.
// - host sees 32 input points as two 16-bit words.
// - lower word carries the selected channel's 16-bit value.
// - upper word holds identifier, unused bits and open-sensor flags.
// - lower word bit 15 is sign; bits 14..0 are magnitude.
// - identifier equals channel number minus one, three bits.
// - identifier occupies the three lowest bits of the upper word.
// - one open flag per channel, bit 0 for channel 1.
// - each immediate read advances the channel; host reads once per channel.
// - 3-bit count select sets contiguous channels; default all eight.
// - channel 1 open flag sits eight bits above identifier base.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "rtd_mux_consts.svh"

module rtd_channel_mux_reporter
  import rtd_mux_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = `CONV_PERIOD_CYC,
  parameter int unsigned TMO_CYC    = `CONV_TMO_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic [31:0] image_points,
  output var  logic        sample_req,
  output var  chan_type    sample_chan,
  input  wire logic        sample_done,
  input  wire logic        sample_open,
  input  wire sample_type  sample_value
);

  // configuration and presentation state
  chan_type    cnt_sel_r;
  logic        conv_en_r;
  chan_type    ptr_r;
  image_type   image_r;
  image_type   image_nxt;
  sample_type  value_mem [8];
  logic [7:0]  open_r;
  logic [15:0] sweep_r;

  // bus handshake and decoded strobes
  logic        setup;
  logic        xfer;
  logic        scan_wr;
  logic        imm_rd;
  logic        cfg_wr;
  logic        advance;
  chan_type    pres_chan;
  logic [31:0] rd_mux;

  // converter side
  store_type   store;
  logic        conv_busy;
  logic        seq_req;
  chan_type    seq_chan;

  // true for every word address the slave answers
  function automatic logic addr_valid(logic [7:0] a);
    if (a[1:0] != 2'h0)
      return 1'b0;
    else if (a == `OFS_IMAGE || a == `OFS_IMAGE_ADV)
      return 1'b1;
    else if (a == `OFS_SCAN || a == `OFS_CONFIG)
      return 1'b1;
    else if (a == `OFS_STATUS)
      return 1'b1;
    else if (a >= `OFS_CHAN_BASE && a <= `OFS_CHAN_LAST)
      return 1'b1;
    else
      return 1'b0;
  endfunction

  // apb phases: answer one cycle after setup, no further wait states
  assign setup   = psel && !penable;
  assign xfer    = psel && penable && pready;
  assign scan_wr = xfer && pwrite && (paddr == `OFS_SCAN);
  assign imm_rd  = xfer && !pwrite && (paddr == `OFS_IMAGE_ADV);
  assign cfg_wr  = xfer && pwrite && (paddr == `OFS_CONFIG);

  // a scan boundary or an immediate read hands over one channel
  assign advance = scan_wr || imm_rd;

  // a shrunken count can strand the pointer; fall back to channel 1
  assign pres_chan = (ptr_r > cnt_sel_r) ? 3'h0 : ptr_r;

  // converter pacing and request sequencing
  conv_sequencer #(
    .PERIOD_CYC (PERIOD_CYC),
    .TMO_CYC    (TMO_CYC)
  ) u_conv (
    .pclk         (pclk),
    .presetn      (presetn),
    .conv_enable  (conv_en_r),
    .count_sel    (cnt_sel_r),
    .sample_done  (sample_done),
    .sample_open  (sample_open),
    .sample_value (sample_value),
    .req          (seq_req),
    .req_chan     (seq_chan),
    .busy         (conv_busy),
    .store        (store)
  );

  // request pins straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_req  <= 1'b0;
      sample_chan <= 3'h0;
    end else begin
      sample_req  <= seq_req;
      sample_chan <= seq_chan;
    end
  end

  // configuration register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_sel_r <= `CNT_SEL_RST;
      conv_en_r <= `CONV_EN_RST;
    end else if (cfg_wr) begin
      if (pstrb[0])
        cnt_sel_r <= pwdata[`CFG_COUNT_LSB +: 3];
      if (pstrb[1])
        conv_en_r <= pwdata[`CFG_CONV_EN_BIT];
    end
  end

  // per-channel store, written whenever a conversion lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++)
        value_mem[i] <= 16'h0000;
    end else if (store.valid) begin
      value_mem[store.chan] <= store.value;
    end
  end

  // open flags follow the latest conversion of each channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_r <= 8'h00;
    end else if (store.valid) begin
      open_r[store.chan] <= store.open_flag;
    end
  end

  // completed sweeps, counted on the last enabled channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sweep_r <= 16'h0000;
    end else if (store.valid && store.chan == cnt_sel_r) begin
      sweep_r <= sweep_r + 16'h0001;
    end
  end

  // presentation pointer: next channel to hand over
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_r <= 3'h0;
    end else if (advance) begin
      // one enabled channel makes next_chan return it every time
      ptr_r <= next_chan(pres_chan, cnt_sel_r);
    end
  end

  // image assembly; value and identifier share one register
  always_comb begin
    image_nxt            = image_r;
    image_nxt.unused     = 5'h00;
    // flags stay live; disabled channels are not processed
    image_nxt.open_flags = open_r & enable_mask(cnt_sel_r);
    if (advance) begin
      image_nxt.data    = value_mem[pres_chan];
      image_nxt.chan_id = pres_chan;
    end
  end

  // single write keeps a sample from pairing stale id with new data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      image_r <= '0;
    end else begin
      image_r <= image_nxt;
    end
  end

  // discrete input points, own flop loaded from the same image_nxt as the bus view
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      image_points <= 32'h0000_0000;
    end else begin
      image_points <= image_nxt;
    end
  end

  // read data selection, evaluated in the setup cycle
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr == `OFS_IMAGE || paddr == `OFS_IMAGE_ADV) begin
      rd_mux = image_r;
    end else if (paddr == `OFS_CONFIG) begin
      rd_mux[`CFG_COUNT_LSB +: 3] = cnt_sel_r;
      rd_mux[`CFG_CONV_EN_BIT]    = conv_en_r;
    end else if (paddr == `OFS_STATUS) begin
      rd_mux[2:0]                 = ptr_r;
      rd_mux[`STS_BUSY_BIT]       = conv_busy;
      rd_mux[`STS_OPEN_LSB +: 8]  = open_r;
      rd_mux[`STS_SWEEP_LSB +: 16] = sweep_r;
    end else if (paddr >= `OFS_CHAN_BASE && paddr <= `OFS_CHAN_LAST) begin
      rd_mux[15:0] = value_mem[paddr[4:2]];
      rd_mux[`OPEN_LSB] = open_r[paddr[4:2]];
    end
  end

  // ready for exactly one cycle per transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // unmapped or misaligned addresses answer with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup && !addr_valid(paddr);
    end
  end

  // read data held through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= (!pwrite && addr_valid(paddr)) ? rd_mux : 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// file: design/rtd_mux_consts.svh
// constants for the rtd channel multiplexer reporter: offsets, fields,
// reset values and timing counts; assumes a 250 MHz pclk
`ifndef RTD_MUX_CONSTS_SVH
`define RTD_MUX_CONSTS_SVH

// register byte offsets on the apb side
`define OFS_IMAGE       8'h00
`define OFS_IMAGE_ADV   8'h04
`define OFS_SCAN        8'h08
`define OFS_CONFIG      8'h0C
`define OFS_STATUS      8'h10
`define OFS_CHAN_BASE   8'h20
`define OFS_CHAN_LAST   8'h3C

// field positions inside the 32-bit input image
`define SIGN_BIT        15
`define ID_LSB          16
`define UNUSED_LSB      19
`define OPEN_LSB        24

// field positions inside config and status
`define CFG_COUNT_LSB   0
`define CFG_CONV_EN_BIT 8
`define STS_BUSY_BIT    3
`define STS_OPEN_LSB    8
`define STS_SWEEP_LSB   16

// reset values
`define CNT_SEL_RST     3'h7
`define CONV_EN_RST     1'h1

// timing: period of pclk and converter pacing
`define CLK_PERIOD_NS   4
`define CONV_PERIOD_NS  2000
`define CONV_TMO_NS     1000
`define CONV_PERIOD_CYC \
  ((`CONV_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_TMO_CYC    (`CONV_TMO_NS / `CLK_PERIOD_NS)

`endif

// file: design/rtd_mux_pkg.sv
// types and helper functions for the rtd channel multiplexer reporter
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package rtd_mux_pkg;

  typedef logic [2:0] chan_type;

  typedef struct packed {
    logic        sign;
    logic [14:0] magnitude;
  } sample_type;

  typedef struct packed {
    logic [7:0] open_flags;
    logic [4:0] unused;
    chan_type   chan_id;
    sample_type data;
  } image_type;

  typedef struct packed {
    logic       valid;
    chan_type   chan;
    logic       open_flag;
    sample_type value;
  } store_type;

  typedef enum logic {CONV_IDLE, CONV_WAIT} conv_state_type;

  // wraps to channel 1 after the last enabled one
  function automatic chan_type next_chan(chan_type cur, chan_type last);
    if (cur >= last)
      return 3'h0;
    return chan_type'(cur + 3'h1);
  endfunction

  // channels are contiguous from channel 1
  function automatic logic [7:0] enable_mask(chan_type last);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++)
      m[i] = (i <= int'(last));
    return m;
  endfunction

endpackage

`default_nettype wire

// file: tb/rtd_front_model.sv
// front end model: answers each conversion request of the reporter
// assumes same clock as the reporter, one request outstanding at a time
`timescale 1ns/10ps
`default_nettype none

module rtd_front_model
  import rtd_mux_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        sample_req,
  input  wire chan_type    sample_chan,
  input  wire logic [7:0]  open_mask,
  input  wire logic [14:0] base,
  output var  logic        sample_done,
  output var  logic        sample_open,
  output var  sample_type  sample_value
);
  int       left;
  chan_type ch;
  logic     slow;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left         <= 0;
      ch           <= 3'h0;
      slow         <= 1'b0;
      sample_done  <= 1'b0;
      sample_open  <= 1'b1;
      sample_value <= sample_type'(16'h5A5A);
    end else begin
      sample_done  <= 1'b0;
      // idle lines wander so a stale answer never looks valid
      sample_open  <= ~sample_open;
      sample_value <= sample_type'(~sample_value);
      if (sample_req) begin
        ch   <= sample_chan;
        left <= slow ? 3 : 1;
        slow <= ~slow;
      end else if (left == 1) begin
        sample_done  <= 1'b1;
        sample_open  <= open_mask[ch];
        sample_value <= open_mask[ch] ? sample_type'(16'h0000) :
                        sample_type'({ch[0], base ^ 15'(ch)});
        left         <= 0;
      end else if (left > 1) begin
        left <= left - 1;
      end
    end
  end
endmodule

`default_nettype wire

// file: tb/rtd_mux_chk.sv
// checker: bus timing and input image layout of the reporter
// assumes binding onto the reporter top, one clock domain
`timescale 1ns/10ps
`default_nettype none

module rtd_mux_chk
#(
  parameter int unsigned PERIOD_CYC = 500,
  parameter int unsigned TMO_CYC    = 250
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] image_points,
  input wire logic        sample_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // completing scan write or immediate read
  wire adv;
  assign adv = psel && penable && pready &&
               ((paddr == 8'h08 && pwrite) || (paddr == 8'h04 && !pwrite));

  ready_after_setup_a: assert property (
    psel && !penable |=> pready && psel && penable)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("error read with data");
  unused_zero_a: assert property (image_points[23:19] == 5'h00)
    else $error("unused bits set");
  pair_change_a: assert property (
    !$stable(image_points[18:0]) |-> $past(adv))
    else $error("data or id moved without advance");
  wrap_one_a: assert property (
    adv && image_points[18:16] == 3'h7 |=> image_points[18:16] == 3'h0)
    else $error("no wrap after channel eight");
  step_order_a: assert property (adv |=>
    image_points[18:16] == 3'h0 ||
    image_points[18:16] == $past(image_points[18:16]) + 3'h1)
    else $error("channel order broken");
  req_pulse_a: assert property (sample_req |=> !sample_req [*3])
    else $error("requests too close");

  cover property (adv && !pwrite);
  cover property (adv && pwrite);
  cover property (pready && pslverr);
  cover property (sample_req);
endmodule

bind rtd_channel_mux_reporter rtd_mux_chk #(
  .PERIOD_CYC(PERIOD_CYC), .TMO_CYC(TMO_CYC)
) i_rtd_mux_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .image_points(image_points), .sample_req(sample_req)
);

`default_nettype wire

// file: tb/tb.sv
// testbench: apb host scanning the reporter, front end model behind it
// assumes the design package, the front end model and the checker
`timescale 1ns/10ps
`default_nettype none

module tb
  import rtd_mux_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        sample_req, sample_done, sample_open;
  logic [7:0]  paddr, omask;
  logic [14:0] base;
  logic [31:0] pwdata, prdata, image_points, rng, rd, pts, st;
  chan_type    sample_chan;
  sample_type  sample_value;
  int          num_errors, check_count, ptr, cur, n_en;
  int          counts [5] = '{8, 1, 2, 5, 3};
  logic [15:0] dest [8];

  always #2 pclk = ~pclk;

  // short counts keep sweeps fast; slow answers stay inside the timeout
  rtd_channel_mux_reporter #(.PERIOD_CYC(12), .TMO_CYC(6))
    i_rtd_channel_mux_reporter (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .image_points(image_points), .sample_req(sample_req),
    .sample_chan(sample_chan), .sample_done(sample_done),
    .sample_open(sample_open), .sample_value(sample_value));

  rtd_front_model i_rtd_front_model (
    .pclk(pclk), .presetn(presetn), .sample_req(sample_req),
    .sample_chan(sample_chan), .open_mask(omask), .base(base),
    .sample_done(sample_done), .sample_open(sample_open),
    .sample_value(sample_value));

  function automatic logic [15:0] dat(int c);
    return omask[c] ? 16'h0000 : {c[0], base ^ 15'(c)};
  endfunction

  function automatic logic [31:0] img(int c);
    logic [7:0] en;
    en = 8'((9'h001 << n_en) - 9'h001);
    return {omask & en, 5'h00, 3'(c), dat(c)};
  endfunction

  task automatic check(string what, logic [32:0] seen, logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (num_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [31:0] xorshift(logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // psel stays up for back-to-back transfers; wait_cyc drops it
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] wd);
    int k;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // sampled at the rising edge, before the slave's flops update
    for (k = 0; k < 8; k++) begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (pready !== 1'b1) begin
      num_errors++;
      conclude();
    end
    rd  = prdata;
    er  = pslverr;
    pts = image_points;
    penable <= 1'b0;
  endtask

  task automatic wait_cyc(int n);
    psel <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask

  task automatic run(int n);
    int s;
    apb(1'b1, 8'h0C, 32'h0000_0100 | 32'(n - 1));
    n_en = n;
    if (ptr >= n)
      ptr = 0;
    wait_cyc(300);
    for (s = 0; s <= 2 * n; s++) begin
      rng = xorshift(rng);
      apb(1'b1, 8'h08, rng);
      cur = ptr;
      ptr = (ptr + 1) % n;
      apb(1'b0, 8'h00, 32'h0);
      check("image", {er, rd}, {1'b0, img(cur)});
      check("points", {1'b0, pts}, {1'b0, img(cur)});
    end
    for (s = 0; s < n; s++) begin
      apb(1'b0, 8'h04, 32'h0);
      dest[rd[18:16] & 3'h7] = rd[15:0];
      check("adv", {er, rd}, {1'b0, img(cur)});
      check("dest", {17'h0, dest[cur]}, {17'h0, dat(cur)});
      cur = ptr;
      ptr = (ptr + 1) % n;
    end
    for (s = 0; s < n; s++) begin
      apb(1'b0, 8'h20 + 8'(4 * s), 32'h0);
      check("chan", {er, rd}, {8'h00, omask[s], 8'h00, dat(s)});
    end
    apb(1'b0, 8'h10, 32'h0);
    check("status ptr", {er, 29'h0, rd[2:0]}, {30'h0, 3'(ptr)});
    wait_cyc(1);
  endtask

  initial begin
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    omask       = 8'h00;
    base        = 15'h0;
    rng         = 32'h3B47;
    num_errors  = 0;
    check_count = 0;
    ptr         = 0;
    cur         = 0;
    n_en        = 8;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("reset", {1'b0, image_points}, 33'h0);
    rng = xorshift(rng);
    base <= rng[14:0];
    rng = xorshift(rng);
    omask <= rng[7:0];
    apb(1'b0, 8'h0C, 32'h0);
    check("config", {er, rd}, 33'h107);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped", {er, rd}, {1'b1, 32'h0});
    apb(1'b0, 8'h02, 32'h0);
    check("misaligned", {er, rd}, {1'b1, 32'h0});
    apb(1'b1, 8'h00, 32'hFFFF_FFFF);
    check("ro write", {er, 32'h0}, 33'h0);
    wait_cyc(1);
    foreach (counts[i])
      run(counts[i]);
    omask <= 8'hFF;
    run(8);
    // conversions off: status must freeze and the converter go idle
    apb(1'b1, 8'h0C, 32'h0000_0007);
    wait_cyc(40);
    apb(1'b0, 8'h10, 32'h0);
    st = rd;
    wait_cyc(100);
    apb(1'b0, 8'h10, 32'h0);
    check("frozen", {er, rd}, {1'b0, st});
    check("idle", {32'h0, rd[3]}, 33'h0);
    conclude();
  end
endmodule

`default_nettype wire
